//--- rtl/xbh_pkg.sv
package xbh_pkg;
	// ***********************************************************
	// shared constants of the external bus handshake
	// ***********************************************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 48;
	localparam int SEL_W = 4;
	localparam int BR_W = 6;
	// wait states the device inserts on an internal memory access
	localparam logic [3:0] MEM_WAIT = 4'h2;
	// wait states the host end waits before a grant is expected
	localparam logic [3:0] HOST_GAP = 4'h1;
	// reset value of the ready drive mode bit: open drain
	localparam logic READY_MODE_RST = 1'b0;
	typedef enum logic [1:0]
	{
		XBH_IDLE = 2'b00,
		XBH_WAIT = 2'b01,
		XBH_DONE = 2'b11
	} xbh_acc_t;
endpackage : xbh_pkg

//--- rtl/xbh_if.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************************
// pins between the device end and the host / agent end
// ***********************************************************
interface xbh_if;
	logic suspend_bus_tristate_n;
	logic host_bus_request_n;
	logic chip_select_n;
	logic host_bus_grant_o;
	logic host_bus_grant_oe;
	logic host_ready_ack_o;
	logic host_ready_ack_oe;
	logic ack_dev_o;
	logic ack_dev_oe;
	logic ack_ext_o;
	logic ack_ext_oe;
	logic write_strobe_n;
	logic sync_write_select_n;
	logic [xbh_pkg::ADDR_W-1:0] addr_o;
	logic [xbh_pkg::DATA_W-1:0] data_o;
	logic [xbh_pkg::SEL_W-1:0] mem_sel_n_o;
	logic strobe_o;
	logic bus_oe;
	logic [xbh_pkg::BR_W-1:0] multiproc_bus_requests_n;
	// wired levels; ack and grant seen by both ends, ready seen by the agent end only
	logic ack_line;
	logic host_ready_line;
	logic host_bus_grant_line;
	// an agent driving ack overrides the master's keeper; with nobody driving it reads high
	assign ack_line = ack_ext_oe ? ack_ext_o : ((ack_dev_oe && !ack_dev_o) ? 1'b0 : 1'b1);
	assign host_ready_line = (host_ready_ack_oe && !host_ready_ack_o) ? 1'b0 : 1'b1;
	assign host_bus_grant_line = (host_bus_grant_oe && !host_bus_grant_o) ? 1'b0 : 1'b1;
	modport device (
		input suspend_bus_tristate_n, host_bus_request_n, chip_select_n, write_strobe_n,
		input sync_write_select_n, multiproc_bus_requests_n, ack_line, host_bus_grant_line,
		output host_bus_grant_o, host_bus_grant_oe, host_ready_ack_o, host_ready_ack_oe,
		output ack_dev_o, ack_dev_oe, addr_o, data_o, mem_sel_n_o, strobe_o, bus_oe
	);
	modport agent (
		output suspend_bus_tristate_n, host_bus_request_n, chip_select_n, write_strobe_n,
		output sync_write_select_n, multiproc_bus_requests_n, ack_ext_o, ack_ext_oe,
		input host_bus_grant_line, host_ready_line, ack_line, bus_oe
	);
endinterface : xbh_if
`default_nettype wire

//--- rtl/xbh_device.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - external agent may hold ack low
// - drive ack low for internal access waits
// - as slave, pull master ack low
// - master keeps ack at last level
// - suspend input floats bus after three edges
// - access stalls until suspend released
// - suspend only for deadlock or dram
// - float bus when suspended or slave
// - host requests bus with request line
// - float bus, then assert host grant
// - host request beats processor requests
// - hold grant until host request released
// - only master drives host grant
// - host selects device with chip select
// - drive host ready low for waits
// - ready open drain, mode bit actives
// - drive ready only with select and request
// - agent write uses write strobe
// - write select early, cancelled without strobe
module xbh_device #(
	parameter logic [3:0] MEM_WAIT = xbh_pkg::MEM_WAIT
)
(
	input wire logic mclk,
	input wire logic srst,
	xbh_if.device bus,
	input wire logic is_master,
	input wire logic ready_drive_mode_select,
	input wire logic ext_req,
	input wire logic ext_write,
	input wire logic [xbh_pkg::ADDR_W-1:0] ext_addr,
	input wire logic [xbh_pkg::DATA_W-1:0] ext_wdata,
	input wire logic [xbh_pkg::SEL_W-1:0] ext_sel_n,
	output logic ext_done,
	input wire logic slave_acc,
	input wire logic host_acc,
	output logic host_granted,
	output logic wr_commit
);
	// ***********************************************************
	// input synchronisers
	// ***********************************************************
	logic hbr_s1, hbr_s2, cs_s1, cs_s2, suspend_bus_tristate_s1, suspend_bus_tristate_s2;
	// asynchronous pins get two stages before any use
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hbr_s1 <= 1'b1;
			hbr_s2 <= 1'b1;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			suspend_bus_tristate_s1 <= 1'b1;
			suspend_bus_tristate_s2 <= 1'b1;
		end
		else
		begin
			hbr_s1 <= bus.host_bus_request_n;
			hbr_s2 <= hbr_s1;
			cs_s1 <= bus.chip_select_n;
			cs_s2 <= cs_s1;
			suspend_bus_tristate_s1 <= bus.suspend_bus_tristate_n;
			suspend_bus_tristate_s2 <= suspend_bus_tristate_s1;
		end
	end
	logic host_req, host_sel, suspended;
	assign host_req = !hbr_s2;
	assign host_sel = !cs_s2;
	assign suspended = !suspend_bus_tristate_s2;

	// ***********************************************************
	// host bus arbitration
	// ***********************************************************
	logic grant;
	logic ext_busy;
	// grant only once our own drive has dropped, so the bus is already floated
	// a waiting access then stalls under the grant instead of deadlocking it
	always_ff @(posedge mclk)
	begin
		if (srst)
			grant <= 1'b0;
		else if (!is_master || !host_req)
			grant <= 1'b0;
		else if (!ext_busy)
			grant <= 1'b1;
	end
	// host request outranks every processor request line
	logic own_bus;
	assign own_bus = is_master && !grant && !host_req;
	assign bus.host_bus_grant_o = !grant;
	assign bus.host_bus_grant_oe = is_master;
	assign host_granted = grant;

	// ***********************************************************
	// external access by this device
	// ***********************************************************
	xbh_pkg::xbh_acc_t acc_st;
	logic [xbh_pkg::ADDR_W-1:0] addr_q;
	logic [xbh_pkg::DATA_W-1:0] data_q;
	logic [xbh_pkg::SEL_W-1:0] sel_q;
	logic wr_q;
	// access holds while suspended and completes on ack only while it owns the bus
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			acc_st <= xbh_pkg::XBH_IDLE;
			addr_q <= '0;
			data_q <= '0;
			sel_q <= '1;
			wr_q <= 1'b0;
		end
		else
		begin
			case (acc_st)
				xbh_pkg::XBH_IDLE:
					if (ext_req && own_bus)
					begin
						acc_st <= xbh_pkg::XBH_WAIT;
						addr_q <= ext_addr;
						data_q <= ext_wdata;
						sel_q <= ext_sel_n;
						wr_q <= ext_write;
					end
				xbh_pkg::XBH_WAIT:
					if (!suspended && own_bus && bus.ack_line)
						acc_st <= xbh_pkg::XBH_DONE;
				xbh_pkg::XBH_DONE:
					acc_st <= xbh_pkg::XBH_IDLE;
				default:
					acc_st <= xbh_pkg::XBH_IDLE;
			endcase
		end
	end
	assign ext_done = acc_st == xbh_pkg::XBH_DONE;

	// ***********************************************************
	// three-state control of the external bus
	// ***********************************************************
	logic drive;
	// registered so a sampled suspend floats the bus on the next cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
			drive <= 1'b0;
		else
			drive <= own_bus && !suspended && acc_st != xbh_pkg::XBH_IDLE;
	end
	assign bus.bus_oe = drive;
	// arbitration sees the bus as busy while it is still driven
	assign ext_busy = drive;
	assign bus.addr_o = addr_q;
	assign bus.data_o = data_q;
	assign bus.mem_sel_n_o = drive ? sel_q : '1;
	assign bus.strobe_o = drive && wr_q;

	// ***********************************************************
	// acknowledge line: slave waits and master keeper
	// ***********************************************************
	logic [3:0] wait_cnt;
	logic slave_wait;
	// count wait states on a synchronous access to internal memory
	always_ff @(posedge mclk)
	begin
		if (srst)
			wait_cnt <= 4'h0;
		else if (!slave_acc)
			wait_cnt <= 4'h0;
		else if (wait_cnt != MEM_WAIT)
			wait_cnt <= wait_cnt + 4'h1;
	end
	assign slave_wait = slave_acc && wait_cnt != MEM_WAIT;
	logic ack_keep;
	// keeper holds the level last driven by others; our own wait pull is not kept,
	// or the master would latch itself low forever
	always_ff @(posedge mclk)
	begin
		if (srst)
			ack_keep <= 1'b1;
		else if (!slave_wait)
			ack_keep <= bus.ack_line;
	end
	assign bus.ack_dev_o = slave_wait ? 1'b0 : ack_keep;
	assign bus.ack_dev_oe = slave_wait || is_master;

	// ***********************************************************
	// host ready line
	// ***********************************************************
	logic [3:0] host_cnt;
	logic host_wait;
	// count wait states of a host access into internal memory
	always_ff @(posedge mclk)
	begin
		if (srst)
			host_cnt <= 4'h0;
		else if (!host_acc)
			host_cnt <= 4'h0;
		else if (host_cnt != MEM_WAIT)
			host_cnt <= host_cnt + 4'h1;
	end
	assign host_wait = host_acc && host_cnt != MEM_WAIT;
	logic ready_en;
	assign ready_en = host_sel && host_req;
	assign bus.host_ready_ack_o = !host_wait;
	// open drain drives low only; active drive also drives the high level
	assign bus.host_ready_ack_oe = ready_en && (host_wait || ready_drive_mode_select);

	// ***********************************************************
	// incoming writes: strobe confirms an early write select
	// ***********************************************************
	logic sw_s1, sw_s2, wr_s1, wr_s2;
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sw_s1 <= 1'b1;
			sw_s2 <= 1'b1;
			wr_s1 <= 1'b1;
			wr_s2 <= 1'b1;
		end
		else
		begin
			sw_s1 <= bus.sync_write_select_n;
			sw_s2 <= sw_s1;
			wr_s1 <= bus.write_strobe_n;
			wr_s2 <= wr_s1;
		end
	end
	logic sw_pend;
	// a select without a following strobe is dropped
	always_ff @(posedge mclk)
	begin
		if (srst)
			sw_pend <= 1'b0;
		else if (!wr_s2)
			sw_pend <= 1'b0;
		else
			sw_pend <= !sw_s2;
	end
	always_ff @(posedge mclk)
	begin
		if (srst)
			wr_commit <= 1'b0;
		else
			wr_commit <= sw_pend && !wr_s2;
	end
endmodule : xbh_device
`default_nettype wire

//--- rtl/xbh_agent.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************************
// host processor and external agent end
// ***********************************************************
module xbh_agent
(
	input wire logic mclk,
	input wire logic srst,
	xbh_if.agent bus,
	input wire logic want_bus,
	input wire logic want_select,
	input wire logic suspend,
	input wire logic hold_ack,
	input wire logic do_write,
	input wire logic cancel_write,
	input wire logic [xbh_pkg::BR_W-1:0] proc_requests,
	output logic bus_granted,
	output logic ready_seen
);
	logic req_q, sel_q, sus_q, sw_q, wr_q, hold_ack_q;
	// host asks for the bus and selects the device; suspend only by choice
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			req_q <= 1'b0;
			sel_q <= 1'b0;
			sus_q <= 1'b0;
		end
		else
		begin
			req_q <= want_bus;
			sel_q <= want_select && want_bus;
			sus_q <= suspend;
		end
	end
	// write select goes first; the strobe follows unless cancelled
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sw_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else
		begin
			sw_q <= do_write;
			wr_q <= sw_q && !cancel_write;
		end
	end
	assign bus.host_bus_request_n = !req_q;
	assign bus.chip_select_n = !sel_q;
	assign bus.suspend_bus_tristate_n = !sus_q;
	assign bus.sync_write_select_n = !sw_q;
	assign bus.write_strobe_n = !wr_q;
	assign bus.multiproc_bus_requests_n = ~proc_requests;
	// drive ack high for one cycle before letting go, so the master's keeper settles high
	always_ff @(posedge mclk)
	begin
		if (srst)
			hold_ack_q <= 1'b0;
		else
			hold_ack_q <= hold_ack;
	end
	assign bus.ack_ext_o = !hold_ack;
	assign bus.ack_ext_oe = hold_ack || hold_ack_q;
	// grant and ready come straight from wired lines on the same clock
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			bus_granted <= 1'b0;
			ready_seen <= 1'b0;
		end
		else
		begin
			bus_granted <= req_q && !bus.host_bus_grant_line;
			ready_seen <= sel_q && bus.host_ready_line;
		end
	end
endmodule : xbh_agent
`default_nettype wire

//--- dv/xbh_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************************
// pin watcher
// ***********************************************************
module xbh_monitor
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic suspend_bus_tristate_n,
	input wire logic host_bus_request_n,
	input wire logic chip_select_n,
	input wire logic host_bus_grant_line,
	input wire logic host_ready_line,
	input wire logic host_ready_ack_oe,
	input wire logic ack_dev_o,
	input wire logic ack_dev_oe,
	input wire logic ack_ext_oe,
	input wire logic bus_oe
);
	// one clock domain, so one default clocking
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// two sync flops plus one edge: four low samples float the bus
	chk_susp_float: assert property ((!suspend_bus_tristate_n)[*4] |-> !bus_oe)
		else $error("bus driven while suspended");
	chk_susp_stall: assert property ((!suspend_bus_tristate_n)[*5] |-> $stable(bus_oe))
		else $error("bus drive changed while suspended");
	chk_grant_sync: assert property (
		$fell(host_bus_request_n) && host_bus_grant_line |-> host_bus_grant_line[*3])
		else $error("grant before request synchronised");
	chk_grant_hold: assert property (
		!host_bus_grant_line && !host_bus_request_n |=> !host_bus_grant_line)
		else $error("grant dropped under request");
	chk_grant_release: assert property ((host_bus_request_n)[*4] |-> host_bus_grant_line)
		else $error("grant kept after release");
	chk_grant_float: assert property ($fell(host_bus_grant_line) |-> !bus_oe)
		else $error("grant while bus driven");
	chk_ready_gate: assert property (
		(chip_select_n || host_bus_request_n)[*4] |-> !host_ready_ack_oe)
		else $error("ready driven without select and request");
	chk_ready_release: assert property (!host_ready_line |-> ##[1:8] host_ready_line)
		else $error("ready held low too long");
	chk_ack_release: assert property (
		ack_dev_oe && !ack_dev_o && !ack_ext_oe |-> ##[1:6] !(ack_dev_oe && !ack_dev_o))
		else $error("ack held low too long");
endmodule : xbh_monitor
`default_nettype wire

//--- dv/external_bus_host_handshake_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************************************
// bench for both ends of the handshake
// ***********************************************************
module external_bus_host_handshake_tb_top;
	logic mclk, srst, is_master, mode, ext_req, slave_acc, host_acc;
	logic want_bus, want_select, suspend, hold_ack, do_write, cancel_write;
	logic ext_write = 1'b1;
	logic [xbh_pkg::ADDR_W-1:0] ext_addr = 32'h0000_0100;
	logic [xbh_pkg::DATA_W-1:0] ext_wdata = 48'h1234_5678_9abc;
	logic [xbh_pkg::SEL_W-1:0] ext_sel_n = 4'he;
	logic [xbh_pkg::BR_W-1:0] proc_requests;
	logic ext_done, host_granted, wr_commit, bus_granted, ready_seen, hit;
	int failures, num_checks;
	xbh_if u_xbh_if ();
	xbh_device u_xbh_device (.mclk(mclk), .srst(srst), .bus(u_xbh_if.device),
		.is_master(is_master), .ready_drive_mode_select(mode), .ext_req(ext_req),
		.ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_sel_n(ext_sel_n), .ext_done(ext_done), .slave_acc(slave_acc),
		.host_acc(host_acc), .host_granted(host_granted), .wr_commit(wr_commit));
	xbh_agent u_xbh_agent (.mclk(mclk), .srst(srst), .bus(u_xbh_if.agent),
		.want_bus(want_bus), .want_select(want_select), .suspend(suspend),
		.hold_ack(hold_ack), .do_write(do_write), .cancel_write(cancel_write),
		.proc_requests(proc_requests), .bus_granted(bus_granted), .ready_seen(ready_seen));
	xbh_monitor u_xbh_monitor (.mclk(mclk), .srst(srst),
		.suspend_bus_tristate_n(u_xbh_if.suspend_bus_tristate_n),
		.host_bus_request_n(u_xbh_if.host_bus_request_n),
		.chip_select_n(u_xbh_if.chip_select_n),
		.host_bus_grant_line(u_xbh_if.host_bus_grant_line),
		.host_ready_line(u_xbh_if.host_ready_line),
		.host_ready_ack_oe(u_xbh_if.host_ready_ack_oe),
		.ack_dev_o(u_xbh_if.ack_dev_o), .ack_dev_oe(u_xbh_if.ack_dev_oe),
		.ack_ext_oe(u_xbh_if.ack_ext_oe),
		.bus_oe(u_xbh_if.bus_oe));
	// 8 ns clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk
	// bounded wait, sampled mid-cycle so flop updates have landed
	task automatic wt(ref logic s, input logic v, input int n, output logic h);
		h = 0;
		repeat (n)
		begin
			if (!h)
			begin
				@(negedge mclk);
				h = (s === v);
			end
		end
	endtask : wt
	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// every other processor requesting too: host must still win
	task automatic t_grant;
		@(posedge mclk);
		is_master <= 1'b1;
		proc_requests <= 6'h3f;
		want_bus <= 1'b1;
		wt(host_granted, 1'b1, 10, hit);
		chk("granted", 1'b1, hit);
		chk("bus_oe", 1'b0, u_xbh_if.bus_oe);
		chk("grant_line", 1'b0, u_xbh_if.host_bus_grant_line);
		@(posedge mclk);
		want_bus <= 1'b0;
		proc_requests <= 6'h00;
		wt(host_granted, 1'b0, 10, hit);
		chk("released", 1'b1, hit);
		$display("grant done");
	endtask : t_grant
	// a slave neither drives grant nor keeps ack long
	task automatic t_slave;
		@(posedge mclk);
		is_master <= 1'b0;
		want_bus <= 1'b1;
		repeat (8) @(negedge mclk);
		chk("grant_oe", 1'b0, u_xbh_if.host_bus_grant_oe);
		@(posedge mclk);
		want_bus <= 1'b0;
		slave_acc <= 1'b1;
		wt(u_xbh_if.ack_line, 1'b0, 8, hit);
		chk("ack_low", 1'b1, hit);
		wt(u_xbh_if.ack_line, 1'b1, 8, hit);
		chk("ack_high", 1'b1, hit);
		@(posedge mclk);
		slave_acc <= 1'b0;
		is_master <= 1'b1;
		repeat (4) @(negedge mclk);
		chk("keeper_oe", 1'b1, u_xbh_if.ack_dev_oe);
		chk("keeper_lvl", 1'b1, u_xbh_if.ack_line);
		$display("slave done");
	endtask : t_slave
	// access held off by ack or by suspend, then completed
	task automatic t_access(input logic by_ack);
		@(posedge mclk);
		hold_ack <= by_ack;
		suspend <= !by_ack;
		repeat (5) @(posedge mclk);
		ext_req <= 1'b1;
		@(posedge mclk);
		ext_req <= 1'b0;
		wt(ext_done, 1'b1, 10, hit);
		chk("stalled", 1'b0, hit);
		// while the access waits: floated under suspend, driven under a held ack
		if (!by_ack)
			chk("susp_oe", 1'b0, u_xbh_if.bus_oe);
		else
			chk("wait_oe", 1'b1, u_xbh_if.bus_oe);
		@(posedge mclk);
		hold_ack <= 1'b0;
		suspend <= 1'b0;
		wt(ext_done, 1'b1, 12, hit);
		chk("done", 1'b1, hit);
		repeat (2) @(negedge mclk);
		chk("ack_kept", 1'b1, u_xbh_if.ack_line);
		$display("access done");
	endtask : t_access
	// ready low for the wait, then high or released per mode
	task automatic t_ready(input logic m);
		@(posedge mclk);
		mode <= m;
		want_bus <= 1'b1;
		want_select <= 1'b1;
		// the access starts once select and request have passed the synchronisers
		repeat (4) @(posedge mclk);
		host_acc <= 1'b1;
		wt(u_xbh_if.host_ready_line, 1'b0, 10, hit);
		chk("ready_low", 1'b1, hit);
		wt(u_xbh_if.host_ready_line, 1'b1, 8, hit);
		chk("ready_high", 1'b1, hit);
		chk("ready_oe", m, u_xbh_if.host_ready_ack_oe);
		@(posedge mclk);
		host_acc <= 1'b0;
		want_select <= 1'b0;
		want_bus <= 1'b0;
		repeat (8) @(negedge mclk);
		chk("ready_off", 1'b0, u_xbh_if.host_ready_ack_oe);
		$display("ready done");
	endtask : t_ready
	// write with strobe commits, early select alone is dropped
	task automatic t_write(input logic cancel);
		@(posedge mclk);
		// the select always goes out; only the strobe is withheld on cancel
		do_write <= 1'b1;
		cancel_write <= cancel;
		wt(wr_commit, 1'b1, 10, hit);
		chk("commit", !cancel, hit);
		@(posedge mclk);
		do_write <= 1'b0;
		cancel_write <= 1'b0;
		repeat (6) @(posedge mclk);
		$display("write done");
	endtask : t_write
	// main sequence, reset held 6 cycles
	initial
	begin
		{srst, is_master, mode, ext_req, slave_acc, host_acc} = 6'h30;
		{want_bus, want_select, suspend, hold_ack, do_write, cancel_write} = 6'h00;
		proc_requests = 6'h00;
		repeat (6) @(posedge mclk);
		srst <= 0;
		repeat (4) @(posedge mclk);
		t_grant();
		t_slave();
		t_access(1);
		t_access(0);
		t_ready(0);
		t_ready(1);
		t_write(0);
		t_write(1);
		print_verdict();
	end
	// watchdog well past the expected run of under 150 cycles
	initial
	begin
		#16000;
		failures++;
		print_verdict();
	end
endmodule : external_bus_host_handshake_tb_top
`default_nettype wire
